/* core/jfdar_regs.sv */
// Debug-port data and address registers driving the program memory interface
`timescale 1ns/1ps
`default_nettype none
`include "jfdar_consts.svh"
// How it works
// - Fail bit goes 1 after a failed memory operation, 0 after a success.
// - Busy bit is 1 while a memory request is in progress, else 0.
// - Data register accesses while busy start no memory operation.
// - Every read, write and erase uses the 16-bit address register, reset zero.
// - Address advances after every read or write, pass or fail.
// - Watchdog stays disabled only while CORE_HALTED_I reports the core halted.
// - Peripherals keep running and in step during debug.
// - Program mode stores the written byte at the address, then advances it.
// - Erase mode fills the addressed page with ones only on key 0xA5.
// - Idle write mode only updates the stored data, no memory operation.
module jfdar_regs
   import jfdar_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK_I,
   input  wire logic        RST_I,
   // Register access from the debug port
   input  wire logic        DAT_WR_I,
   input  wire logic        DAT_RD_I,
   input  wire logic [9:0]  DAT_WDATA_I,
   output logic      [9:0]  DAT_RDATA_O,
   input  wire logic        ADR_WR_I,
   input  wire logic [15:0] ADR_WDATA_I,
   output logic      [15:0] ADR_RDATA_O,
   input  wire logic [2:0]  WRITE_MODE_SELECT_I,
   input  wire logic [3:0]  READ_MODE_SELECT_I,
   // Program memory interface
   output logic             MEM_REQ_O,
   output logic      [1:0]  MEM_OP_O,
   output logic      [15:0] MEM_ADDR_O,
   output logic      [7:0]  MEM_WDATA_O,
   input  wire logic        MEM_DONE_I,
   input  wire logic        MEM_FAIL_I,
   input  wire logic [7:0]  MEM_RDATA_I,
   // Debug side effects
   input  wire logic        CORE_HALTED_I,
   output logic             WATCHDOG_TIMER_EN_O,
   output logic             PERIPH_CLK_EN_O
);

   // Operation in progress; its code doubles as the memory operation code
   jfdar_state_e      state_q;
   jfdar_state_e      state_d;
   // Data byte shared by idle writes, program data and read results
   logic [7:0]        byte_q;
   logic [7:0]        byte_d;
   // Outcome of the last finished memory operation
   logic              fail_q;
   logic              fail_d;
   // Target of every read, write and erase
   logic [15:0]       adr_q;
   logic [15:0]       adr_d;
   // A fetched byte that no data register read has taken yet
   logic              unread_q;
   logic              unread_d;

   // Byte field of a data register write; bits 1..0 are status and are dropped
   function automatic logic [7:0] byte_field(input logic [9:0] wdata);
      byte_field = wdata[`JFDAR_BYTE_MSB:`JFDAR_BYTE_LSB];
   endfunction : byte_field

   // Whether a data register read in this mode fetches a new byte
   function automatic logic read_fetches(input logic [3:0] mode, input logic unread);
      case (mode)
         `JFDAR_RD_BLOCK:  read_fetches = 1'b1;
         `JFDAR_RD_SINGLE: read_fetches = !unread;
         default:          read_fetches = 1'b0;
      endcase
   endfunction : read_fetches

   // Data register image: byte above fail above busy
   function automatic logic [9:0] status_word(input logic [7:0] data, input logic failed,
                                              input logic pending);
      status_word = {data, failed, pending};
   endfunction : status_word

   // Access qualification: nothing is taken while an operation is pending
   wire        busy;
   wire        wr_ok;
   wire        rd_ok;
   wire        adr_ok;
   wire [7:0]  wr_byte;
   assign busy    = (state_q != JFDAR_IDLE);
   assign wr_ok   = DAT_WR_I && !busy;
   assign rd_ok   = DAT_RD_I && !busy;
   // Loading the address mid-operation would retarget it, so it is ignored too
   assign adr_ok  = ADR_WR_I && !busy;
   assign wr_byte = byte_field(DAT_WDATA_I);

   // Start decode
   wire        wr_prog;
   wire        wr_erase;
   wire        key_ok;
   wire        start_prog;
   wire        start_erase;
   wire        start_read;
   wire        read_skip;
   assign wr_prog     = (WRITE_MODE_SELECT_I == `JFDAR_WR_PROG);
   assign wr_erase    = (WRITE_MODE_SELECT_I == `JFDAR_WR_ERASE);
   assign key_ok      = (wr_byte == `JFDAR_ERASE_KEY);
   assign start_prog  = wr_ok && wr_prog;
   // Without the key an erase-mode write only stores the byte
   assign start_erase = wr_ok && wr_erase && key_ok;
   // Single mode hands out a fetched byte before it fetches the next one
   assign start_read  = rd_ok && read_fetches(READ_MODE_SELECT_I, unread_q);
   assign read_skip   = rd_ok && !start_read;

   // Completion
   wire        done;
   wire        done_read;
   wire        adv;
   assign done      = busy && MEM_DONE_I;
   assign done_read = done && (state_q == JFDAR_READ);
   // Erase works on a whole page, so the address is left where it was
   assign adv       = done && (state_q != JFDAR_ERASE);

   // One operation at a time; a write outranks a read issued in the same cycle
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         JFDAR_IDLE: begin
            if (start_prog) begin
               state_d = JFDAR_WRITE;
            end else if (start_erase) begin
               state_d = JFDAR_ERASE;
            end else if (start_read) begin
               state_d = JFDAR_READ;
            end
         end
         JFDAR_READ, JFDAR_WRITE, JFDAR_ERASE: begin
            if (MEM_DONE_I) begin
               state_d = JFDAR_IDLE;
            end
         end
      endcase
   end

   // Next data byte: a taken write wins, else a finished read loads it
   always_comb begin
      byte_d = byte_q;
      if (wr_ok) begin
         byte_d = wr_byte;
      end else if (done_read) begin
         byte_d = MEM_RDATA_I;
      end
   end

   // Every completion, erase included, reports its own outcome
   assign fail_d = done ? MEM_FAIL_I : fail_q;

   // A read that fetches nothing consumes the pending byte
   always_comb begin
      unread_d = unread_q;
      if (done_read) begin
         unread_d = 1'b1;
      end else if (read_skip) begin
         unread_d = 1'b0;
      end
   end

   // A direct load and a step never meet: the step needs busy, the load idle
   always_comb begin
      adr_d = adr_q;
      if (adr_ok) begin
         adr_d = ADR_WDATA_I;
      end else if (adv) begin
         adr_d = adr_q + 16'h0001;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         state_q <= JFDAR_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         byte_q <= 8'h00;
      end else begin
         byte_q <= byte_d;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         fail_q <= 1'b0;
      end else begin
         fail_q <= fail_d;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         adr_q <= `JFDAR_ADR_RST;
      end else begin
         adr_q <= adr_d;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         unread_q <= 1'b0;
      end else begin
         unread_q <= unread_d;
      end
   end

   // Data register read image and address readback
   assign DAT_RDATA_O = status_word(byte_q, fail_q, busy);
   assign ADR_RDATA_O = adr_q;

   // Memory interface: request level, operation code, target and data
   assign MEM_REQ_O   = busy;
   assign MEM_OP_O    = state_q;
   assign MEM_ADDR_O  = adr_q;
   assign MEM_WDATA_O = byte_q;

   // No register delay, so the watchdog never counts a halted cycle
   assign WATCHDOG_TIMER_EN_O = !CORE_HALTED_I;
   // Peripheral clocks never gate on debug state, keeping them in step
   assign PERIPH_CLK_EN_O = 1'b1;

endmodule : jfdar_regs
`default_nettype wire

/* common/jfdar_consts.svh */
// Constants for the debug-port program memory data and address registers
`ifndef JFDAR_CONSTS_SVH
`define JFDAR_CONSTS_SVH
`define JFDAR_DAT_W        10
`define JFDAR_ADR_W        16
`define JFDAR_DAT_RST      10'h000
`define JFDAR_ADR_RST      16'h0000
`define JFDAR_BUSY_BIT     0
`define JFDAR_FAIL_BIT     1
`define JFDAR_BYTE_LSB     2
`define JFDAR_BYTE_MSB     9
`define JFDAR_ERASE_KEY    8'ha5
`define JFDAR_ERASED_BYTE  8'hff
`define JFDAR_WR_IDLE      3'h0
`define JFDAR_WR_PROG      3'h1
`define JFDAR_WR_ERASE     3'h2
`define JFDAR_RD_IDLE      4'h0
`define JFDAR_RD_BLOCK     4'h1
`define JFDAR_RD_SINGLE    4'h2
`endif

/* common/jfdar_pkg.sv */
// Types for the debug-port program memory data and address registers
package jfdar_pkg;
   typedef enum logic [1:0] {
      JFDAR_IDLE  = 2'h0,
      JFDAR_READ  = 2'h1,
      JFDAR_WRITE = 2'h3,
      JFDAR_ERASE = 2'h2
   } jfdar_state_e;
endpackage : jfdar_pkg

/* tb/jfdar_props.sv */
// Checker on the register block ports
`timescale 1ns/1ps
`default_nettype none
module jfdar_props (input wire logic CLK_I, RST_I, DAT_WR_I, DAT_RD_I, MEM_REQ_O, MEM_DONE_I,
   input wire logic MEM_FAIL_I, CORE_HALTED_I, WATCHDOG_TIMER_EN_O,
   input wire logic [1:0] MEM_OP_O, input wire logic [9:0] DAT_WDATA_I, DAT_RDATA_O,
   input wire logic [15:0] ADR_RDATA_O, input wire logic [2:0] WRITE_MODE_SELECT_I);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   wire st = DAT_WR_I && !MEM_REQ_O, dn = MEM_REQ_O && MEM_DONE_I, bz = MEM_REQ_O && !MEM_DONE_I;
   wire [2:0] wm = WRITE_MODE_SELECT_I;
   wire [7:0] wb = DAT_WDATA_I[9:2];
   // Erase completion leaves the address where it was
   wire [15:0] nx = ADR_RDATA_O + 16'(MEM_OP_O != 2'h2);
   // Busy never appears without an access, and the status bit tracks the request
   property p_bsy; !MEM_REQ_O && !DAT_WR_I && !DAT_RD_I
      |=> !MEM_REQ_O && DAT_RDATA_O[0] == MEM_REQ_O; endproperty
   a_bsy: assert property (p_bsy) else $error("busy");
   property p_hld; bz |=> $stable({DAT_RDATA_O, ADR_RDATA_O}); endproperty
   a_hld: assert property (p_hld) else $error("hold");
   property p_fl; dn |=> !MEM_REQ_O && DAT_RDATA_O[1] == $past(MEM_FAIL_I); endproperty
   a_fl: assert property (p_fl) else $error("fail");
   property p_inc; dn |=> ADR_RDATA_O == $past(nx); endproperty
   a_inc: assert property (p_inc) else $error("step");
   property p_prg; st && wm == 3'h1 |=> MEM_REQ_O && MEM_OP_O == 2'h3; endproperty
   a_prg: assert property (p_prg) else $error("prog");
   property p_idl; st && wm == 3'h0 |=> !MEM_REQ_O && DAT_RDATA_O[9:2] == $past(wb); endproperty
   a_idl: assert property (p_idl) else $error("idle");
   property p_key; st && wm == 3'h2 |=> MEM_REQ_O == ($past(wb) == 8'ha5)
      && (!MEM_REQ_O || MEM_OP_O == 2'h2); endproperty
   a_key: assert property (p_key) else $error("key");
   property p_wd; WATCHDOG_TIMER_EN_O == !CORE_HALTED_I; endproperty
   a_wd: assert property (p_wd) else $error("wdog");
   c_fl: cover property (dn && MEM_FAIL_I);
   c_er: cover property (dn && MEM_OP_O == 2'h2);
   c_rd: cover property (dn && MEM_OP_O == 2'h1);
endmodule : jfdar_props
`default_nettype wire

/* tb/jfdar_mem_model.sv */
// Program memory stand-in: done dly_i+1 cycles after the request, upper half locked
`timescale 1ns/1ps
`default_nettype none
module jfdar_mem_model (input wire logic clk_i, rst_i, req_i, input wire logic [15:0] adr_i,
   input wire logic [3:0] dly_i, output logic done_o, fail_o, output logic [7:0] rd_o);
   logic [3:0] n_q;
   wire go = req_i && !done_o && !rst_i;
   always_ff @(posedge clk_i) begin
      n_q <= go ? n_q + 4'h1 : 4'h0;
      done_o <= go && n_q == dly_i;
      fail_o <= adr_i[15];
      // Toggles whenever n_q differs from dly_i so a stale byte is never mistaken for data
      rd_o <= n_q == dly_i ? adr_i[7:0] ^ 8'h5a : ~rd_o;
   end
endmodule : jfdar_mem_model
`default_nettype wire

/* tb/tb_jtag_flash_data_address_regs.sv */
// Self-checking bench for the debug-port data and address registers
`timescale 1ns/1ps
`default_nettype none
module tb_jtag_flash_data_address_regs;
   logic CLK_I=0, RST_I=1, DAT_WR_I=0, DAT_RD_I=0, ADR_WR_I=0, CORE_HALTED_I=0, MEM_REQ_O, go;
   logic MEM_DONE_I, MEM_FAIL_I, WATCHDOG_TIMER_EN_O, PERIPH_CLK_EN_O;
   logic [9:0] DAT_WDATA_I=0, DAT_RDATA_O;
   logic [15:0] ADR_WDATA_I=0, ADR_RDATA_O, MEM_ADDR_O;
   logic [7:0] MEM_WDATA_O, MEM_RDATA_I;
   logic [3:0] READ_MODE_SELECT_I=4'h1, dly=0;
   logic [2:0] WRITE_MODE_SELECT_I=0;
   logic [1:0] MEM_OP_O;
   int fails=0, n_checks=0, ea=0, ef=0, eb=0, ur=0;
   jfdar_regs dut_u (.*);
   jfdar_mem_model mem_u (.clk_i(CLK_I), .rst_i(RST_I), .req_i(MEM_REQ_O), .adr_i(MEM_ADDR_O),
      .dly_i(dly), .done_o(MEM_DONE_I), .fail_o(MEM_FAIL_I), .rd_o(MEM_RDATA_I));
   initial forever #5 CLK_I = ~CLK_I;
   initial begin #60000; fails++; report_and_stop(); end
   task automatic chk(input string n, input logic [15:0] e, g);
      n_checks++;
      if (g !== e) begin fails++; $display("BAD %s exp %h got %h", n, e, g); end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : report_and_stop
   // Code c: 0 idle write, 1 program, 2 erase, 3 read in mode m; a poke lands while busy
   task automatic op(input int c, input logic [7:0] b);
      int m;
      m = $urandom % 3;
      // Single mode fetches only once the previous byte has been read out
      go = c == 3 ? (m == 1 || (m == 2 && ur == 0)) : c != 0 && (c != 2 || b == 8'ha5);
      @(posedge CLK_I); DAT_WR_I <= c < 3; DAT_RD_I <= c == 3; ADR_WR_I <= 0;
      WRITE_MODE_SELECT_I <= 3'(c % 3); READ_MODE_SELECT_I <= 4'(m);
      DAT_WDATA_I <= {b, 2'(c)}; dly <= 4'($urandom % 10);
      CORE_HALTED_I <= 1'($urandom); ADR_WDATA_I <= 16'($urandom);
      @(posedge CLK_I); DAT_WR_I <= go; DAT_RD_I <= 0; ADR_WR_I <= go; DAT_WDATA_I <= ~DAT_WDATA_I;
      WRITE_MODE_SELECT_I <= 3'h1; @(posedge CLK_I); DAT_WR_I <= 0; ADR_WR_I <= 0; #1;
      for (int k = 0; k < 30 && DAT_RDATA_O[0] !== 1'b0; k++) @(posedge CLK_I) #1;
      if (c < 3) eb = b; else if (go) eb = (ea & 'hff) ^ 'h5a;
      if (c == 3) ur = go;
      if (go) ef = ea[15];
      if (go && c != 2) ea = (ea + 1) & 'hffff;
      chk("data", {8'(eb), 1'(ef), 1'b0}, DAT_RDATA_O);
      chk("addr", 16'(ea), ADR_RDATA_O);
      chk("wdog", {1'b1, !CORE_HALTED_I}, {PERIPH_CLK_EN_O, WATCHDOG_TIMER_EN_O});
      chk("wdat", 16'(eb), MEM_WDATA_O);
      $display("op %0d done", c);
   endtask : op
   initial begin
      void'($urandom(32'h4e1a7dcc)); repeat (16) @(posedge CLK_I); RST_I <= 0; #1;
      chk("data", 0, DAT_RDATA_O); chk("addr", 0, ADR_RDATA_O);
      // Start near the top so locked failures and the address wrap both occur
      @(posedge CLK_I); ADR_WR_I <= 1; ADR_WDATA_I <= 16'hfffc; ea = 'hfffc;
      for (int i = 0; i < 96; i++) op(i % 4, i % 8 == 2 ? 8'ha5 : 8'($urandom));
      report_and_stop();
   end
endmodule : tb_jtag_flash_data_address_regs
bind jfdar_regs jfdar_props chk_u (.*);
`default_nettype wire
